// ### design/alarm_flags_consts.vh
`ifndef ALARM_FLAGS_CONSTS_VH
`define ALARM_FLAGS_CONSTS_VH

// Register offsets on the serial control port
`define REG_LIVE_SIGNAL_LOSS   8'h81
`define REG_LIVE_OFFSET_LOCK   8'h82
`define REG_LATCHED_LOSS       8'h83
`define REG_LATCHED_OFFSET     8'h84
`define REG_ACTIVE_INPUT       8'h80

// Field positions, live signal-loss register and its latched twin
`define BIT_IN2_LOSS           2
`define BIT_IN1_LOSS           1
`define BIT_REFOSC_LOSS        0

// Field positions, live offset/lock register
`define BIT_HOLD_READY         6
`define BIT_IN2_FOS_LIVE       2
`define BIT_IN1_FOS_LIVE       1
`define BIT_UNLOCK_LIVE        0

// Field positions, latched offset/lock register
`define BIT_IN2_FOS_LATCH      3
`define BIT_IN1_FOS_LATCH      2
`define BIT_UNLOCK_LATCH       1

// Field positions, active-input register
`define BIT_IN2_ACTIVE         1
`define BIT_IN1_ACTIVE         0

`define DATA_ZERO              8'h00
`define LOSS_FLAG_RESET        3'h0
`define OFFSET_FLAG_RESET      3'h0

`endif

// ### design/alarm_sync3.v
`timescale 1ns/10ps
// Three-stage synchroniser; output moves only when stages two and three agree
module alarm_sync3 #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             ref_clk_in,
  input  wire             rst_b_in,
  input  wire             clk_en_in,
  // Data
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] mid_q;
  reg [WIDTH-1:0] last_q;
  integer         i;

  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_q   <= {WIDTH{1'b0}};
      mid_q    <= {WIDTH{1'b0}};
      last_q   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else if (clk_en_in) begin
      meta_q <= async_in;
      mid_q  <= meta_q;
      last_q <= mid_q;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (mid_q[i] == last_q[i]) begin
          sync_out[i] <= last_q[i];
        end
      end
    end
  end

endmodule // alarm_sync3

// ### design/clock_alarm_status_flags.v
`timescale 1ns/10ps
`include "alarm_flags_consts.vh"

module clock_alarm_status_flags (
  // Clock, reset, enable
  input  wire       ref_clk_in,
  input  wire       rst_b_in,
  input  wire       clk_en_in,
  // Alarm detectors (other clock domains)
  input  wire       in2_signal_loss_live_in,
  input  wire       in1_signal_loss_live_in,
  input  wire       refosc_signal_loss_live_in,
  input  wire       in2_freq_offset_live_in,
  input  wire       in1_freq_offset_live_in,
  input  wire       pll_unlock_live_in,
  input  wire       hold_history_ready_in,
  // Input selection from clock switching logic
  input  wire       in1_selected_in,
  input  wire       in2_selected_in,
  // Mask and pin-enable settings (same clock)
  input  wire       irq_pin_enable_in,
  input  wire       in2_signal_loss_mask_in,
  input  wire       in1_signal_loss_mask_in,
  input  wire       refosc_signal_loss_mask_in,
  input  wire       in2_freq_offset_mask_in,
  input  wire       in1_freq_offset_mask_in,
  input  wire       pll_unlock_mask_in,
  // Register port from the serial control engine
  input  wire [7:0] reg_addr_in,
  input  wire [7:0] reg_wdata_in,
  input  wire       reg_wr_in,
  input  wire       reg_rd_in,
  output reg  [7:0] reg_rdata_out,
  output reg        reg_rvalid_out,
  // Alarm outputs
  output reg        irq_out,
  output reg        in1_active_out,
  output reg        in2_active_out
);

  wire [6:0] live_sync;
  reg  [6:0] live_prev_q;
  reg  [2:0] loss_flags_q;
  reg  [2:0] loss_flags_d;
  reg  [2:0] offset_flags_q;
  reg  [2:0] offset_flags_d;
  reg  [7:0] rdata_d;
  reg        irq_d;

  // Live alarm index map inside live_sync
  localparam L_IN2_LOS = 6;
  localparam L_IN1_LOS = 5;
  localparam L_OSC_LOS = 4;
  localparam L_IN2_FOS = 3;
  localparam L_IN1_FOS = 2;
  localparam L_UNLOCK  = 1;
  localparam L_HOLD    = 0;

  wire in2_los   = live_sync[L_IN2_LOS];
  wire in1_los   = live_sync[L_IN1_LOS];
  wire osc_los   = live_sync[L_OSC_LOS];
  wire in2_fos   = live_sync[L_IN2_FOS];
  wire in1_fos   = live_sync[L_IN1_FOS];
  wire unlock    = live_sync[L_UNLOCK];
  wire hold_rdy  = live_sync[L_HOLD];

  // Detectors run on their own clocks, so every live alarm is resynchronised
  alarm_sync3 #(
    .WIDTH (7)
  ) u_live_sync (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .clk_en_in  (clk_en_in),
    .async_in   ({in2_signal_loss_live_in, in1_signal_loss_live_in,
                  refosc_signal_loss_live_in, in2_freq_offset_live_in,
                  in1_freq_offset_live_in, pll_unlock_live_in,
                  hold_history_ready_in}),
    .sync_out   (live_sync)
  );

  // Rising edge of a live alarm sets its flag
  function rise;
    input now_v;
    input was_v;
    begin
      rise = now_v & ~was_v;
    end
  endfunction

  // Next flag: a set wins over a same-cycle clear
  function next_flag;
    input cur_v;
    input set_v;
    input clr_v;
    begin
      next_flag = set_v | (cur_v & ~clr_v);
    end
  endfunction

  // Register images; each starts from zero so reserved bits read 0
  function [7:0] pack_live_loss;
    input in2_v;
    input in1_v;
    input osc_v;
    begin
      pack_live_loss                   = `DATA_ZERO;
      pack_live_loss[`BIT_IN2_LOSS]    = in2_v;
      pack_live_loss[`BIT_IN1_LOSS]    = in1_v;
      pack_live_loss[`BIT_REFOSC_LOSS] = osc_v;
    end
  endfunction

  // Live offset and lock image
  function [7:0] pack_live_offset;
    input hold_v;
    input in2_v;
    input in1_v;
    input unl_v;
    begin
      pack_live_offset                    = `DATA_ZERO;
      pack_live_offset[`BIT_HOLD_READY]   = hold_v;
      pack_live_offset[`BIT_IN2_FOS_LIVE] = in2_v;
      pack_live_offset[`BIT_IN1_FOS_LIVE] = in1_v;
      pack_live_offset[`BIT_UNLOCK_LIVE]  = unl_v;
    end
  endfunction

  // Latched signal-loss image
  function [7:0] pack_loss_flags;
    input in2_v;
    input in1_v;
    input osc_v;
    begin
      pack_loss_flags                   = `DATA_ZERO;
      pack_loss_flags[`BIT_IN2_LOSS]    = in2_v;
      pack_loss_flags[`BIT_IN1_LOSS]    = in1_v;
      pack_loss_flags[`BIT_REFOSC_LOSS] = osc_v;
    end
  endfunction

  // Latched offset and lock image; bit 0 stays reserved
  function [7:0] pack_offset_flags;
    input in2_v;
    input in1_v;
    input unl_v;
    begin
      pack_offset_flags                     = `DATA_ZERO;
      pack_offset_flags[`BIT_IN2_FOS_LATCH] = in2_v;
      pack_offset_flags[`BIT_IN1_FOS_LATCH] = in1_v;
      pack_offset_flags[`BIT_UNLOCK_LATCH]  = unl_v;
    end
  endfunction

  // Active-input image
  function [7:0] pack_active;
    input in1_act_v;
    input in2_act_v;
    begin
      pack_active                  = `DATA_ZERO;
      pack_active[`BIT_IN2_ACTIVE] = in2_act_v;
      pack_active[`BIT_IN1_ACTIVE] = in1_act_v;
    end
  endfunction

  // Read data decode; unmapped offsets read as zero
  function [7:0] read_mux;
    input [7:0] addr_v;
    input [6:0] live_v;
    input [2:0] loss_v;
    input [2:0] off_v;
    input       in1_act_v;
    input       in2_act_v;
    begin
      case (addr_v)
        `REG_LIVE_SIGNAL_LOSS: begin
          read_mux = pack_live_loss(live_v[L_IN2_LOS], live_v[L_IN1_LOS],
                                    live_v[L_OSC_LOS]);
        end
        `REG_LIVE_OFFSET_LOCK: begin
          read_mux = pack_live_offset(live_v[L_HOLD], live_v[L_IN2_FOS],
                                      live_v[L_IN1_FOS], live_v[L_UNLOCK]);
        end
        `REG_LATCHED_LOSS:   read_mux = pack_loss_flags(loss_v[2], loss_v[1], loss_v[0]);
        `REG_LATCHED_OFFSET: read_mux = pack_offset_flags(off_v[2], off_v[1], off_v[0]);
        `REG_ACTIVE_INPUT:   read_mux = pack_active(in1_act_v, in2_act_v);
        default:             read_mux = `DATA_ZERO;
      endcase
    end
  endfunction

  // Register hit: strobe high and offset equal to the register's own
  function wr_hit;
    input       strobe_v;
    input [7:0] addr_v;
    input [7:0] reg_v;
    begin
      wr_hit = strobe_v & (addr_v == reg_v);
    end
  endfunction

  // Only the two flag registers take writes; everything else is ignored
  wire wr_loss   = wr_hit(reg_wr_in, reg_addr_in, `REG_LATCHED_LOSS);
  wire wr_offset = wr_hit(reg_wr_in, reg_addr_in, `REG_LATCHED_OFFSET);

  // Flags follow rising edges only, so a still-high alarm stays cleared
  // History resets to 0 like the synchroniser, so no false edge follows reset
  wire in2_los_rise = rise(in2_los, live_prev_q[L_IN2_LOS]);
  wire in1_los_rise = rise(in1_los, live_prev_q[L_IN1_LOS]);
  wire osc_los_rise = rise(osc_los, live_prev_q[L_OSC_LOS]);
  wire in2_fos_rise = rise(in2_fos, live_prev_q[L_IN2_FOS]);
  wire in1_fos_rise = rise(in1_fos, live_prev_q[L_IN1_FOS]);
  wire unlock_rise  = rise(unlock, live_prev_q[L_UNLOCK]);

  // A written 0 clears its flag, a written 1 is no clear at all
  // Same-cycle set and clear: the set wins inside next_flag
  wire in2_los_clr = wr_loss & ~reg_wdata_in[`BIT_IN2_LOSS];
  wire in1_los_clr = wr_loss & ~reg_wdata_in[`BIT_IN1_LOSS];
  wire osc_los_clr = wr_loss & ~reg_wdata_in[`BIT_REFOSC_LOSS];
  wire in2_fos_clr = wr_offset & ~reg_wdata_in[`BIT_IN2_FOS_LATCH];
  wire in1_fos_clr = wr_offset & ~reg_wdata_in[`BIT_IN1_FOS_LATCH];
  wire unlock_clr  = wr_offset & ~reg_wdata_in[`BIT_UNLOCK_LATCH];

  // Loss flag next-state
  always @* begin
    loss_flags_d[2] = next_flag(loss_flags_q[2], in2_los_rise, in2_los_clr);
    loss_flags_d[1] = next_flag(loss_flags_q[1], in1_los_rise, in1_los_clr);
    loss_flags_d[0] = next_flag(loss_flags_q[0], osc_los_rise, osc_los_clr);
  end

  // Offset and lock flag next-state
  always @* begin
    offset_flags_d[2] = next_flag(offset_flags_q[2], in2_fos_rise, in2_fos_clr);
    offset_flags_d[1] = next_flag(offset_flags_q[1], in1_fos_rise, in1_fos_clr);
    offset_flags_d[0] = next_flag(offset_flags_q[0], unlock_rise, unlock_clr);
  end

  // A flag requests an interrupt unless its mask bit is set
  function masked_req;
    input flag_v;
    input mask_v;
    begin
      masked_req = flag_v & ~mask_v;
    end
  endfunction

  // Unmasked interrupt sources, one per latched flag
  wire [5:0] irq_src;
  assign irq_src[5] = masked_req(offset_flags_d[2], in2_freq_offset_mask_in);
  assign irq_src[4] = masked_req(offset_flags_d[1], in1_freq_offset_mask_in);
  assign irq_src[3] = masked_req(offset_flags_d[0], pll_unlock_mask_in);
  assign irq_src[2] = masked_req(loss_flags_d[2], in2_signal_loss_mask_in);
  assign irq_src[1] = masked_req(loss_flags_d[1], in1_signal_loss_mask_in);
  assign irq_src[0] = masked_req(loss_flags_d[0], refosc_signal_loss_mask_in);

  // Interrupt from next flag state so irq_out tracks the flags cycle for cycle
  always @* begin
    irq_d = irq_pin_enable_in & (|irq_src);
  end

  always @* begin
    rdata_d = read_mux(reg_addr_in, live_sync, loss_flags_q, offset_flags_q,
                       in1_active_out, in2_active_out);
  end

  // A lost input is never reported active, whatever the selection
  reg in1_active_d;
  reg in2_active_d;
  always @* begin
    in1_active_d = in1_selected_in & ~in1_los;
    in2_active_d = in2_selected_in & ~in2_los;
  end

  // Alarm history for edge detection
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      live_prev_q <= 7'h00;
    end else if (clk_en_in) begin
      live_prev_q <= live_sync;
    end
  end

  // Latched loss flags
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      loss_flags_q <= `LOSS_FLAG_RESET;
    end else if (clk_en_in) begin
      loss_flags_q <= loss_flags_d;
    end
  end

  // Latched offset and lock flags
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      offset_flags_q <= `OFFSET_FLAG_RESET;
    end else if (clk_en_in) begin
      offset_flags_q <= offset_flags_d;
    end
  end

  // Registered so the pin never glitches between flag updates
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_out <= 1'b0;
    end else if (clk_en_in) begin
      irq_out <= irq_d;
    end
  end

  // Active-input indications
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      in1_active_out <= 1'b0;
      in2_active_out <= 1'b0;
    end else if (clk_en_in) begin
      in1_active_out <= in1_active_d;
      in2_active_out <= in2_active_d;
    end
  end

  // Read data holds until the next read so a slow host can pick it up late
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out  <= `DATA_ZERO;
      reg_rvalid_out <= 1'b0;
    end else if (clk_en_in) begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= rdata_d;
      end
    end
  end

endmodule // clock_alarm_status_flags

// ### dv/alarm_flags_monitor.sv
`timescale 1ns/10ps
module alarm_flags_monitor (
  // Clock and register port
  input wire       ref_clk_in,
  input wire       rst_b_in,
  input wire       clk_en_in,
  input wire [7:0] reg_addr_in,
  input wire       reg_rd_in,
  input wire [7:0] reg_rdata_out,
  input wire       reg_rvalid_out,
  // Alarms and outputs
  input wire       in1_signal_loss_live_in,
  input wire       in2_signal_loss_live_in,
  input wire       irq_pin_enable_in,
  input wire       irq_out,
  input wire       in1_active_out,
  input wire       in2_active_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence rd_at(a);
    reg_rd_in && clk_en_in && reg_addr_in == a;
  endsequence
  rd_pulse_a: assert property (clk_en_in |=> reg_rvalid_out == $past(reg_rd_in))
    else $error("read valid mismatch");
  loss_rsvd_a: assert property (rd_at(8'h81) |=> reg_rdata_out[7:3] == 5'h00)
    else $error("reserved bits set");
  live_rsvd_a: assert property (rd_at(8'h82) |=> {reg_rdata_out[7], reg_rdata_out[5:3]} == 4'h0)
    else $error("reserved bits set");
  lflag_rsvd_a: assert property (rd_at(8'h83) |=> reg_rdata_out[7:3] == 5'h00)
    else $error("reserved bits set");
  oflag_rsvd_a: assert property (rd_at(8'h84) |=> {reg_rdata_out[7:4], reg_rdata_out[0]} == 5'h00)
    else $error("reserved bits set");
  unmapped_rd_a: assert property (reg_rd_in && clk_en_in && reg_addr_in > 8'h84 |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  irq_off_a: assert property (clk_en_in && !irq_pin_enable_in |=> !irq_out)
    else $error("interrupt while pin disabled");
  // Eight cycles covers the synchroniser plus the output register
  act1_loss_a: assert property ((in1_signal_loss_live_in && clk_en_in)[*8] |-> !in1_active_out)
    else $error("input one active during loss");
  act2_loss_a: assert property ((in2_signal_loss_live_in && clk_en_in)[*8] |-> !in2_active_out)
    else $error("input two active during loss");
endmodule // alarm_flags_monitor

bind clock_alarm_status_flags alarm_flags_monitor mon (.*);

// ### dv/alarm_host_model.sv
`timescale 1ns/10ps
module alarm_host_model (
  // Clock
  input  wire       ref_clk_in,
  // Register port
  output reg  [7:0] reg_addr_in,
  output reg  [7:0] reg_wdata_in,
  output reg        reg_wr_in,
  output reg        reg_rd_in,
  input  wire [7:0] reg_rdata_out,
  input  wire       reg_rvalid_out
);
  initial {reg_addr_in, reg_wdata_in, reg_wr_in, reg_rd_in} = 18'h0;
  // A zero clears a flag, a one leaves it alone
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge ref_clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b0;
      // Released lines carry junk so a stale value cannot pass
      reg_addr_in <= ~a;
      reg_wdata_in <= ~d;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(posedge ref_clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_rd_in <= 1'b0;
      reg_addr_in <= ~a;
      @(posedge ref_clk_in);
      d = reg_rvalid_out ? reg_rdata_out : ~reg_rdata_out;
    end
  endtask
endmodule // alarm_host_model

// ### dv/clock_alarm_status_flags_tb.sv
`timescale 1ns/10ps
module clock_alarm_status_flags_tb;
  reg        ref_clk_in, rst_b_in, clk_en_in, irq_pin_enable_in;
  reg  [6:0] al;
  reg  [5:0] mk;
  reg  [1:0] sel;
  wire [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
  wire       reg_wr_in, reg_rd_in, reg_rvalid_out, irq_out, in1_active_out, in2_active_out;
  wire refosc_signal_loss_live_in = al[0], in1_signal_loss_live_in = al[1];
  wire in2_signal_loss_live_in = al[2], in1_freq_offset_live_in = al[3];
  wire in2_freq_offset_live_in = al[4], pll_unlock_live_in = al[5], hold_history_ready_in = al[6];
  wire refosc_signal_loss_mask_in = mk[0], in1_signal_loss_mask_in = mk[1];
  wire in2_signal_loss_mask_in = mk[2], pll_unlock_mask_in = mk[3];
  wire in1_freq_offset_mask_in = mk[4], in2_freq_offset_mask_in = mk[5];
  wire in1_selected_in = sel[0], in2_selected_in = sel[1];
  integer    fail_count = 0, n_tests = 0, i;
  reg [31:0] s;
  reg  [7:0] d, a;
  reg  [6:0] prev, r;
  reg  [5:0] fl;

  clock_alarm_status_flags dut (.*);
  alarm_host_model host (.*);

  function [31:0] lfsr(input [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task check(input [7:0] got, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    repeat (3000) @(posedge ref_clk_in);
    fail_count = fail_count + 1;
    stop_test;
  end
  initial begin
    {rst_b_in, clk_en_in, irq_pin_enable_in, al, mk, sel} = 18'h18000;
    {s, prev, fl} = {32'hE410D2B0, 13'h0};
    repeat (3) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    for (i = 0; i < 40; i = i + 1) begin
      s = lfsr(s);
      // Corner cases: clear loss flags with alarms held high, then all drop
      if (i == 0) s = 32'h0002_807F;
      if (i == 1) s = 32'h0003_6000;
      @(posedge ref_clk_in);
      al <= s[6:0];
      mk <= s[12:7] & s[20:15];
      sel <= s[14:13];
      irq_pin_enable_in <= s[15];
      repeat (8) @(posedge ref_clk_in);
      r = s[6:0] & ~prev;
      prev = s[6:0];
      fl = fl | {r[4], r[3], r[5], r[2:0]};
      host.rd(8'h81, d); check(d, {5'h0, al[2:0]});
      host.rd(8'h82, d); check(d, {1'b0, al[6], 3'h0, al[4:3], al[5]});
      host.rd(8'h83, d); check(d, {5'h0, fl[2:0]});
      host.rd(8'h84, d); check(d, {4'h0, fl[5:3], 1'b0});
      host.rd(8'h80, d); check(d, {6'h0, sel & ~al[2:1]});
      host.rd(8'h90 | s[19:16], d); check(d, 8'h00);
      a = 8'h81 + {6'h0, s[17:16]};
      host.wr(a, s[31:24]);
      if (a == 8'h83) fl[2:0] = fl[2:0] & s[26:24];
      if (a == 8'h84) fl[5:3] = fl[5:3] & s[27:25];
      #1;
      check({7'h0, irq_out}, {7'h0, irq_pin_enable_in & |(fl & ~mk)});
      $display("iteration %0d done", i);
    end
    stop_test;
  end
endmodule // clock_alarm_status_flags_tb
